// [hw/step_seq_params.svh]
`ifndef STEP_SEQ_PARAMS_SVH
`define STEP_SEQ_PARAMS_SVH

// Register byte offsets
`define REF_BASE_OFS     12'h000
`define STEP_BASE_OFS    12'h040
`define CTRL_OFS         12'h080
`define STATUS_OFS       12'h084

// Control register fields and reset value
`define CTRL_MODE_LSB    0
`define CTRL_RET_PF_BIT  2
`define CTRL_RET_ST_BIT  3
`define CTRL_UNIT_BIT    4
`define CTRL_SRC_LSB     5
`define CTRL_DEST_LSB    8
`define CTRL_SEQ_EN_BIT  10
`define CTRL_RESET       11'h000

// Step word fields
`define STEP_ACC_LSB     16

// Reference limits in tenths of a percent
`define REF_MAX          16'sh03e8
`define REF_MIN          -16'sh03e8
`define REF_FULL_SCALE   1000

// Run modes
`define MODE_STOP_END    2'h0
`define MODE_HOLD_END    2'h1
`define MODE_REPEAT      2'h2

// First reference sources
`define SRC_STORED       3'h0
`define SRC_AN_ONE       3'h1
`define SRC_AN_TWO       3'h2
`define SRC_AN_THREE     3'h3
`define SRC_PULSE        3'h4
`define SRC_PID          3'h5
`define SRC_PRESET       3'h6

// Output destinations
`define DEST_FREQ        2'h0
`define DEST_VOLT        2'h1
`define DEST_PID         2'h2

// Timing
`define CLK_PERIOD_NS    8
`define TENTH_SEC_NS     100000000
`define TENTH_SEC_CYCLES (`TENTH_SEC_NS / `CLK_PERIOD_NS)
`define TENTHS_PER_HOUR  3600
`define LAST_STEP        4'hf

`endif

// [hw/step_seq_pkg.sv]
package step_seq_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} seq_state_t;
	typedef logic signed [15:0] ref_t;
endpackage

// [hw/step_table_mem.sv]
`timescale 1ns/1ps
// Sixteen entries of reference, step time and ramp set; two registered read ports
module step_table_mem (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      we_ref_i,
	input  wire logic                      we_step_i,
	input  wire logic [3:0]                waddr_i,
	input  wire step_seq_pkg::ref_t        wref_i,
	input  wire logic [15:0]               wtime_i,
	input  wire logic [1:0]                wacc_i,
	input  wire logic [3:0]                a_addr_i,
	input  wire logic [3:0]                b_addr_i,
	output step_seq_pkg::ref_t             a_ref_o,
	output logic      [15:0]               a_time_o,
	output logic      [1:0]                a_acc_o,
	output step_seq_pkg::ref_t             b_ref_o,
	output logic      [15:0]               b_time_o,
	output logic      [1:0]                b_acc_o
);
	step_seq_pkg::ref_t ref_q  [16];
	logic [15:0]        time_q [16];
	logic [1:0]         acc_q  [16];

	// One storage slot per entry, all zero after reset
	for (genvar i = 0; i < 16; i++) begin : g_ent
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				ref_q[i]  <= 16'sh0000;
				time_q[i] <= 16'h0000;
				acc_q[i]  <= 2'h0;
			end else if (waddr_i == 4'(i)) begin
				if (we_ref_i) ref_q[i] <= wref_i;
				if (we_step_i) begin
					time_q[i] <= wtime_i;
					acc_q[i]  <= wacc_i;
				end
			end
		end
	end

	// Registered read ports
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_ref_o  <= 16'sh0000;
			a_time_o <= 16'h0000;
			a_acc_o  <= 2'h0;
			b_ref_o  <= 16'sh0000;
			b_time_o <= 16'h0000;
			b_acc_o  <= 2'h0;
		end else begin
			a_ref_o  <= ref_q[a_addr_i];
			a_time_o <= time_q[a_addr_i];
			a_acc_o  <= acc_q[a_addr_i];
			b_ref_o  <= ref_q[b_addr_i];
			b_time_o <= time_q[b_addr_i];
			b_acc_o  <= acc_q[b_addr_i];
		end
	end
endmodule

// [hw/step_sequencer.sv]
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "step_seq_params.svh"
// Summary of operation
// - Sixteen signed references, clamped to plus or minus 100.0 percent, zero at reset.
// - Frequency scales by maximum frequency, voltage by rated voltage, PID passes unchanged.
// - Terminal input pattern picks which reference is active.
// - Sequencer output can feed frequency or separated voltage command.
// - Mode 0 stops the drive after one cycle until a new run.
// - Mode 1 holds the last step's value and direction after one cycle.
// - Mode 2 restarts at the first step every cycle until stopped.
// - Negative active reference commands reverse rotation when driving frequency.
// - Units retention digit set keeps step position across power loss.
// - Tens retention digit set keeps step position across stop.
// - Each step has a running time up to 6553.5 units, zero by default.
// - Each step has a two-bit ramp time set selection.
// - Shared time unit selects seconds or hours for all step times.
// - First reference source: stored, three analog, pulse, PID or preset value.
module step_sequencer #(
	parameter int unsigned TENTH_CYCLES = `TENTH_SEC_CYCLES
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               psel_i,
	input  wire logic               penable_i,
	input  wire logic               pwrite_i,
	input  wire logic [11:0]        paddr_i,
	input  wire logic [31:0]        pwdata_i,
	output logic      [31:0]        prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o,
	input  wire logic [3:0]         digital_input_terminal_i,
	input  wire logic               run_i,
	input  wire logic               power_fail_i,
	input  wire logic               power_on_i,
	input  wire step_seq_pkg::ref_t analog_input_one_i,
	input  wire step_seq_pkg::ref_t analog_input_two_i,
	input  wire step_seq_pkg::ref_t analog_input_three_i,
	input  wire step_seq_pkg::ref_t pulse_ref_i,
	input  wire step_seq_pkg::ref_t pid_out_i,
	input  wire step_seq_pkg::ref_t preset_frequency_value_i,
	input  wire logic [15:0]        max_freq_i,
	input  wire logic [15:0]        rated_voltage_i,
	output logic      [15:0]        freq_cmd_o,
	output logic                    reverse_o,
	output logic      [15:0]        voltage_cmd_o,
	output step_seq_pkg::ref_t      pid_setpoint_o,
	output logic      [1:0]         accel_sel_o,
	output logic                    drive_run_o,
	output logic      [3:0]         step_o
);
	step_seq_pkg::seq_state_t state_q;
	step_seq_pkg::ref_t       out_ref_q, a_ref, b_ref, wref, src_ref;
	logic [10:0] ctrl_q;
	logic [15:0] a_time, b_time, elapsed_q;
	logic [1:0]  a_acc, b_acc, acc_q;
	logic [3:0]  step_q, a_addr, a_addr_q, res_step_q, pf_step_q;
	logic [15:0] res_el_q, pf_el_q;
	logic [31:0] pre_q;
	logic [11:0] hour_q;
	logic        run_prev_q, a_valid, tick, unit_tick, wr_en, start, stop_ev;
	logic        at_time, adv;
	logic [1:0]  mode, dest;
	logic        seq_en;
	logic [9:0]  mag;
	logic [25:0] fprod, vprod;

	assign mode   = ctrl_q[`CTRL_MODE_LSB +: 2];
	assign dest   = ctrl_q[`CTRL_DEST_LSB +: 2];
	assign seq_en = ctrl_q[`CTRL_SEQ_EN_BIT];

	// APB decode; write lands at the completing edge
	assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
	assign wref  = ($signed(pwdata_i[15:0]) > `REF_MAX) ? `REF_MAX :
	               ($signed(pwdata_i[15:0]) < `REF_MIN) ? `REF_MIN :
	               $signed(pwdata_i[15:0]);

	// Sequencer reads its step; otherwise the terminal pattern picks the entry
	assign a_addr  = seq_en ? step_q : digital_input_terminal_i;
	assign a_valid = (a_addr_q == a_addr);

	step_table_mem u_mem (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.we_ref_i  (wr_en && paddr_i[11:6] == 6'h00),
		.we_step_i (wr_en && paddr_i[11:6] == 6'h01),
		.waddr_i   (paddr_i[5:2]),
		.wref_i    (wref),
		.wtime_i   (pwdata_i[15:0]),
		.wacc_i    (pwdata_i[`STEP_ACC_LSB +: 2]),
		.a_addr_i  (a_addr),
		.b_addr_i  (paddr_i[5:2]),
		.a_ref_o   (a_ref),
		.a_time_o  (a_time),
		.a_acc_o   (a_acc),
		.b_ref_o   (b_ref),
		.b_time_o  (b_time),
		.b_acc_o   (b_acc)
	);

	// APB answer: pready in the second access cycle, data registered with it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i & penable_i & ~pready_o;
			pslverr_o <= psel_i & penable_i & ~pready_o & (paddr_i[11:3] > 9'h010 ||
			             paddr_i[1:0] != 2'h0);
			if (paddr_i[11:6] == 6'h00)
				prdata_o <= {{16{b_ref[15]}}, b_ref};
			else if (paddr_i[11:6] == 6'h01)
				prdata_o <= {14'h0000, b_acc, b_time};
			else if (paddr_i == `CTRL_OFS)
				prdata_o <= {21'h000000, ctrl_q};
			else if (paddr_i == `STATUS_OFS)
				prdata_o <= {24'h000000, drive_run_o, 1'b0, 2'(state_q), step_q};
			else
				prdata_o <= 32'h0000_0000;
		end
	end

	// Control register
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctrl_q <= `CTRL_RESET;
		else if (wr_en && paddr_i == `CTRL_OFS)
			ctrl_q <= pwdata_i[10:0];
	end

	// Tenth-of-second prescaler and tenth-of-hour divider
	assign tick      = (pre_q == TENTH_CYCLES - 1);
	assign unit_tick = tick & (~ctrl_q[`CTRL_UNIT_BIT] |
	                   (hour_q == 12'(`TENTHS_PER_HOUR - 1)));
	always_ff @(posedge clk_i) begin
		if (rst_i || state_q != step_seq_pkg::ST_RUN) begin
			pre_q  <= 32'h0000_0000;
			hour_q <= 12'h000;
		end else begin
			pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
			if (tick)
				hour_q <= (hour_q == 12'(`TENTHS_PER_HOUR - 1)) ? 12'h000 : hour_q + 12'h001;
		end
	end

	// Step timing
	assign start   = run_i & ~run_prev_q & seq_en;
	assign stop_ev = ~run_i & run_prev_q;
	assign at_time = (elapsed_q + 16'h0001 >= a_time);
	assign adv     = state_q == step_seq_pkg::ST_RUN && a_valid &&
	                 (a_time == 16'h0000 || (unit_tick && at_time));

	// Sequencer state, step and elapsed time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q    <= step_seq_pkg::ST_IDLE;
			step_q     <= 4'h0;
			elapsed_q  <= 16'h0000;
			run_prev_q <= 1'b0;
			a_addr_q   <= 4'h0;
		end else begin
			run_prev_q <= run_i;
			a_addr_q   <= a_addr;
			if (power_fail_i || power_on_i || stop_ev || !seq_en) begin
				state_q <= step_seq_pkg::ST_IDLE;
			end else if (start) begin
				state_q   <= step_seq_pkg::ST_RUN;
				step_q    <= res_step_q;
				elapsed_q <= res_el_q;
			end else if (adv) begin
				elapsed_q <= 16'h0000;
				if (step_q != `LAST_STEP)
					step_q <= step_q + 4'h1;
				else if (mode == `MODE_REPEAT)
					step_q <= 4'h0;
				else if (mode == `MODE_HOLD_END)
					state_q <= step_seq_pkg::ST_HOLD;
				else
					state_q <= step_seq_pkg::ST_IDLE;
			end else if (state_q == step_seq_pkg::ST_RUN && a_valid && unit_tick) begin
				elapsed_q <= elapsed_q + 16'h0001;
			end
		end
	end

	// Resume point: kept at stop or across power loss when selected
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res_step_q <= 4'h0;
			res_el_q   <= 16'h0000;
			pf_step_q  <= 4'h0;
			pf_el_q    <= 16'h0000;
		end else if (power_fail_i) begin
			pf_step_q <= step_q;
			pf_el_q   <= elapsed_q;
		end else if (power_on_i) begin
			res_step_q <= ctrl_q[`CTRL_RET_PF_BIT] ? pf_step_q : 4'h0;
			res_el_q   <= ctrl_q[`CTRL_RET_PF_BIT] ? pf_el_q : 16'h0000;
		end else if (stop_ev && state_q != step_seq_pkg::ST_IDLE) begin
			res_step_q <= ctrl_q[`CTRL_RET_ST_BIT] ? step_q : 4'h0;
			res_el_q   <= ctrl_q[`CTRL_RET_ST_BIT] ? elapsed_q : 16'h0000;
		end else if (stop_ev) begin
			res_step_q <= ctrl_q[`CTRL_RET_ST_BIT] ? res_step_q : 4'h0;
			res_el_q   <= ctrl_q[`CTRL_RET_ST_BIT] ? res_el_q : 16'h0000;
		end
	end

	// First reference source selection
	always_comb begin
		case (ctrl_q[`CTRL_SRC_LSB +: 3])
			`SRC_STORED:   src_ref = a_ref;
			`SRC_AN_ONE:   src_ref = analog_input_one_i;
			`SRC_AN_TWO:   src_ref = analog_input_two_i;
			`SRC_AN_THREE: src_ref = analog_input_three_i;
			`SRC_PULSE:    src_ref = pulse_ref_i;
			`SRC_PID:      src_ref = pid_out_i;
			`SRC_PRESET:   src_ref = preset_frequency_value_i;
			default:       src_ref = a_ref;
		endcase
	end

	// Active reference and ramp set; zero-time steps never load while sequencing, terminal picks load any entry
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_ref_q <= 16'sh0000;
			acc_q     <= 2'h0;
		end else if (!seq_en) begin
			if (a_valid) begin
				out_ref_q <= (a_addr == 4'h0) ? src_ref : a_ref;
				acc_q     <= a_acc;
			end
		end else if (state_q == step_seq_pkg::ST_RUN && a_valid && a_time != 16'h0000) begin
			out_ref_q <= (step_q == 4'h0) ? src_ref : a_ref;
			acc_q     <= a_acc;
		end
	end

	// Scaling of the active reference
	assign mag   = out_ref_q[15] ? 10'(-out_ref_q) : out_ref_q[9:0];
	assign fprod = mag * max_freq_i;
	assign vprod = mag * rated_voltage_i;

	// Command outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			freq_cmd_o     <= 16'h0000;
			voltage_cmd_o  <= 16'h0000;
			reverse_o      <= 1'b0;
			pid_setpoint_o <= 16'sh0000;
			accel_sel_o    <= 2'h0;
			drive_run_o    <= 1'b0;
			step_o         <= 4'h0;
		end else begin
			freq_cmd_o     <= (dest == `DEST_FREQ) ? 16'(fprod / `REF_FULL_SCALE) : 16'h0000;
			voltage_cmd_o  <= (dest == `DEST_VOLT) ? 16'(vprod / `REF_FULL_SCALE) : 16'h0000;
			reverse_o      <= (dest == `DEST_FREQ) & out_ref_q[15];
			pid_setpoint_o <= out_ref_q;
			accel_sel_o    <= acc_q;
			drive_run_o    <= seq_en ? (state_q != step_seq_pkg::ST_IDLE) : run_i;
			step_o         <= step_q;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence last_step_done;
		adv && step_q == `LAST_STEP && !power_fail_i && !power_on_i && !stop_ev && seq_en;
	endsequence

	ref_in_span_a: assert property (
		pid_setpoint_o <= `REF_MAX && pid_setpoint_o >= `REF_MIN)
		else $error("active reference outside span");
	skip_zero_a: assert property (
		state_q == step_seq_pkg::ST_RUN && a_valid && a_time == 16'h0000 && !stop_ev &&
		!power_fail_i && !power_on_i && seq_en |=> $stable(out_ref_q))
		else $error("zero-time step applied");
	stop_end_a: assert property (
		last_step_done and mode == `MODE_STOP_END |=> state_q == step_seq_pkg::ST_IDLE
		##1 !drive_run_o)
		else $error("mode 0 did not stop");
	hold_end_a: assert property (
		last_step_done and mode == `MODE_HOLD_END |=> state_q == step_seq_pkg::ST_HOLD
		##1 drive_run_o && $stable(out_ref_q))
		else $error("mode 1 did not hold");
	repeat_wrap_a: assert property (
		last_step_done and mode == `MODE_REPEAT |=>
		state_q == step_seq_pkg::ST_RUN && step_q == 4'h0)
		else $error("mode 2 did not wrap");
	reverse_sign_a: assert property (
		dest == `DEST_FREQ && out_ref_q < 0 && $stable(dest) |=> reverse_o)
		else $error("negative reference not reversed");
	pid_pass_a: assert property (
		1'b1 |=> pid_setpoint_o == $past(out_ref_q))
		else $error("pid setpoint converted");
	elapsed_tick_a: assert property (
		elapsed_q == $past(elapsed_q) + 16'h0001 |-> $past(unit_tick))
		else $error("elapsed moved without unit tick");
	stop_resume_a: assert property (
		start && !power_fail_i && !power_on_i |=> step_q == $past(res_step_q))
		else $error("start ignored resume point");

	// Steps of stopping from a running or holding sequence
	sequence stop_in_run;
		stop_ev && state_q != step_seq_pkg::ST_IDLE && !power_fail_i && !power_on_i;
	endsequence
	// Ordinary advance inside a cycle
	sequence step_adv;
		adv && step_q != `LAST_STEP && !power_fail_i && !power_on_i && !stop_ev && seq_en;
	endsequence

	terminal_pick_a: assert property (
		!seq_en && a_valid && a_addr != 4'h0 |=> out_ref_q == $past(a_ref))
		else $error("terminal pattern not applied");
	step_ramp_a: assert property (
		seq_en && state_q == step_seq_pkg::ST_RUN && a_valid && a_time != 16'h0000
		|=> acc_q == $past(a_acc))
		else $error("step ramp set not taken");
	ramp_out_a: assert property (
		1'b1 |=> accel_sel_o == $past(acc_q))
		else $error("ramp set output wrong");
	volt_zero_a: assert property (
		dest != `DEST_VOLT |=> voltage_cmd_o == 16'h0000)
		else $error("voltage command while not selected");
	freq_zero_a: assert property (
		dest != `DEST_FREQ |=> freq_cmd_o == 16'h0000 && !reverse_o)
		else $error("frequency command while not selected");
	sec_tick_a: assert property (
		!ctrl_q[`CTRL_UNIT_BIT] && tick |-> unit_tick)
		else $error("seconds unit missed a tick");
	pf_idle_a: assert property (
		power_fail_i |=> state_q == step_seq_pkg::ST_IDLE && pf_step_q == $past(step_q))
		else $error("power loss not saved");
	pon_load_a: assert property (
		power_on_i && !power_fail_i |=>
		res_step_q == ($past(ctrl_q[`CTRL_RET_PF_BIT]) ? $past(pf_step_q) : 4'h0))
		else $error("power-up resume point wrong");
	stop_save_a: assert property (
		stop_in_run |=> state_q == step_seq_pkg::ST_IDLE &&
		res_step_q == ($past(ctrl_q[`CTRL_RET_ST_BIT]) ? $past(step_q) : 4'h0))
		else $error("stop resume point wrong");
	step_advance_a: assert property (
		step_adv |=> step_q == $past(step_q) + 4'h1 && elapsed_q == 16'h0000)
		else $error("step did not advance");
endmodule

// [test/drive_stage_model.sv]
`timescale 1ns/1ps
// Far-side control stages: command in, scale bases and applied signed speed out
module drive_stage_model #(
	parameter int MAX_FREQ = 500,
	parameter int RATED_V  = 380
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] freq_cmd_i,
	input  wire logic        reverse_i,
	input  wire logic        drive_run_i,
	output logic      [15:0] max_freq_o,
	output logic      [15:0] rated_voltage_o,
	output int               speed_o
);
	// Fixed scale bases of the motor stage
	assign max_freq_o = 16'(MAX_FREQ);
	assign rated_voltage_o = 16'(RATED_V);
	// Speed follows command with sign; zero while stopped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			speed_o <= 0;
		end else begin
			speed_o <= drive_run_i ? (reverse_i ? -int'(freq_cmd_i) : int'(freq_cmd_i)) : 0;
		end
	end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
`include "step_seq_params.svh"
module tb_top;
	logic               clk_i, rst_i, psel, penable, pwrite, pready, pslverr, pfail, pon;
	logic               run, rev, drun;
	logic        [11:0] paddr;
	logic        [31:0] pwdata, prdata, r;
	logic        [15:0] maxf, ratv, freq, volt;
	logic        [3:0]  term, step;
	logic        [1:0]  acc;
	logic               e, mon, skipbad;
	step_seq_pkg::ref_t an1, an2, an3, pls, pid, pre, pids;
	int                 speed, failures, checked, cyc, seed, v;
	int                 refm[16];
	int                 srcm[7];

	step_sequencer #(.TENTH_CYCLES(4)) step_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.digital_input_terminal_i(term), .run_i(run), .power_fail_i(pfail),
		.power_on_i(pon), .analog_input_one_i(an1), .analog_input_two_i(an2),
		.analog_input_three_i(an3), .pulse_ref_i(pls), .pid_out_i(pid),
		.preset_frequency_value_i(pre), .max_freq_i(maxf), .rated_voltage_i(ratv),
		.freq_cmd_o(freq), .reverse_o(rev), .voltage_cmd_o(volt), .pid_setpoint_o(pids),
		.accel_sel_o(acc), .drive_run_o(drun), .step_o(step));
	drive_stage_model drive_stage_model_i (.clk_i(clk_i), .rst_i(rst_i), .freq_cmd_i(freq),
		.reverse_i(rev), .drive_run_i(drun), .max_freq_o(maxf), .rated_voltage_o(ratv),
		.speed_o(speed));

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Hang guard and skipped-step ramp watch
	always @(posedge clk_i) begin
		cyc++;
		if (mon && acc === 2'h3) skipbad <= 1'b1;
		if (cyc == 30000) begin
			failures++;
			give_verdict();
		end
	end

	task give_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask
	// One APB transfer; waits for the slave's ready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		@(posedge clk_i);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 50) failures++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("rdata", x, r);
	endtask
	function int ab(input int x);
		return x < 0 ? -x : x;
	endfunction
	// Model of scaled outputs for a reference and destination
	task out_chk(input int q, input int d);
		chk("freq", (d == 0) ? ab(q) * 500 / 1000 : 0, freq);
		chk("rev", (d == 0 && q < 0), rev);
		chk("volt", (d == 1) ? ab(q) * 380 / 1000 : 0, volt);
		chk("pid", q, pids);
	endtask
	task wstep(input logic [3:0] k);
		int n;
		n = 0;
		while (step !== k && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		chk("step", k, step);
	endtask
	// One sequencer cycle in a given end mode
	task seq(input int m);
		wr(`CTRL_OFS, 32'h400 | m);
		run <= 1'b1;
		wstep(4'h2);
		repeat (5) @(posedge clk_i);
		out_chk(refm[2], 0);
		chk("acc", 2, acc);
		wstep(4'hf);
		repeat (5) @(posedge clk_i);
		out_chk(refm[15], 0);
		repeat (20) @(posedge clk_i);
		if (m == 0) chk("drun", 0, drun);
		if (m == 1) chk("drun", 1, drun);
		if (m == 1) chk("speed", -300, speed);
		if (m == 2) wstep(4'h2);
		run <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("drun", 0, drun);
	endtask
	// Resume after stop or after power loss, retention on or off
	task keep(input int p, input int k);
		wr(`CTRL_OFS, 32'h400 | (p ? k << 2 : k << 3));
		run <= 1'b1;
		wstep(4'h2);
		if (p) begin
			pfail <= 1'b1;
			@(posedge clk_i);
			pfail <= 1'b0;
		end
		run <= 1'b0;
		repeat (3) @(posedge clk_i);
		pon <= p[0];
		@(posedge clk_i);
		pon <= 1'b0;
		repeat (3) @(posedge clk_i);
		run <= 1'b1;
		repeat (4) @(posedge clk_i);
		if (p) chk("resume", k ? 2 : 0, step);
		else chk("resume", k ? 2 : 0, step);
		run <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, run, pfail, pon, term, mon} = '0;
		{an1, an2, an3, pls, pid, pre} = '0;
		{failures, checked, cyc} = '0;
		skipbad = 1'b0;
		seed = 32'h371b9ae1;
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(`CTRL_OFS, 32'h0);
		rdc(`STATUS_OFS, 32'h0);
		rdc(`STEP_BASE_OFS + 12'h014, 32'h0);
		rdc(`REF_BASE_OFS + 12'h01c, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk("slverr", 1, e);
		// References with out-of-range values clamped
		for (int i = 0; i < 16; i++) begin
			v = $random(seed) % 2000;
			refm[i] = v > 1000 ? 1000 : (v < -1000 ? -1000 : v);
			wr(`REF_BASE_OFS + 12'(4 * i), 32'(v));
			rdc(`REF_BASE_OFS + 12'(4 * i), 32'(refm[i]));
		end
		// Terminal selection into every destination
		for (int d = 0; d < 3; d++) begin
			wr(`CTRL_OFS, 32'(d << 8));
			for (int i = 0; i < 16; i++) begin
				term <= 4'(i);
				repeat (6) @(posedge clk_i);
				out_chk(refm[i], d);
			end
		end
		// Every source of reference zero
		term <= 4'h0;
		for (int s = 0; s < 7; s++) begin
			srcm[0] = refm[0];
			for (int j = 1; j < 7; j++) srcm[j] = $random(seed) % 1000;
			{an1, an2, an3} <= {16'(srcm[1]), 16'(srcm[2]), 16'(srcm[3])};
			{pls, pid, pre} <= {16'(srcm[4]), 16'(srcm[5]), 16'(srcm[6])};
			wr(`CTRL_OFS, 32'(s << 5));
			repeat (6) @(posedge clk_i);
			out_chk(srcm[s], 0);
		end
		// Step table: step 1 zero time, steps 3 to 14 zero from reset
		refm[2] = 450;
		refm[15] = -600;
		wr(`REF_BASE_OFS + 12'h008, 32'd450);
		wr(`REF_BASE_OFS + 12'h03c, -32'sd600);
		wr(`STEP_BASE_OFS, 32'h10002);
		wr(`STEP_BASE_OFS + 12'h004, 32'h30000);
		wr(`STEP_BASE_OFS + 12'h008, 32'h20003);
		wr(`STEP_BASE_OFS + 12'h03c, 32'h00004);
		mon = 1'b1;
		for (int m = 0; m < 3; m++) seq(m);
		for (int p = 0; p < 2; p++) for (int k = 0; k < 2; k++) keep(p, k);
		// Hour unit holds step zero far longer
		wr(`CTRL_OFS, 32'h410);
		run <= 1'b1;
		repeat (60) @(posedge clk_i);
		chk("hour", 0, step);
		run <= 1'b0;
		chk("skip", 0, skipbad);
		give_verdict();
	end
endmodule
